/* design/bimf_config_bank.sv */
// Configuration bank: buffer policy, watermark count, event routing to two pins, sampling setup
`timescale 1ns/10ps
module bimf_config_bank
    import bimf_pkg::*;
#(
    parameter int NUM_EVENTS = BIMF_NUM_EVENTS
) (
    input  wire logic                  ref_clk,
    input  wire logic                  srst,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    output logic      [7:0]            reg_rdata,
    output logic                       reg_rvalid,
    input  wire logic [NUM_EVENTS-1:0] event_state,
    output logic      [NUM_EVENTS-1:0] event_status,
    output logic                       irq_pin_a_o,
    output logic                       irq_pin_a_oe_n,
    output logic                       irq_pin_b_o,
    output logic                       irq_pin_b_oe_n,
    input  wire logic                  irq_pin_b_i,
    output logic      [1:0]            buffer_mode,
    output logic                       buffer_enable,
    output logic                       buffer_temp_store,
    output logic      [8:0]            buffer_watermark_level,
    output logic      [1:0]            range_select,
    output logic                       narrow_filter_select,
    output logic      [2:0]            sample_rate_index,
    output logic      [2:0]            filter_bw_div_log2,
    output logic                       external_trigger_select,
    output logic                       external_trigger_pulse
);
    initial begin
        if (NUM_EVENTS != 7) $error("bimf_config_bank: NUM_EVENTS must be 7");
    end

    // Maps a bus address to its store index; 3'h7 marks unmapped
    function automatic logic [2:0] addr_to_idx(input logic [7:0] a);
        unique case (a)
            BIMF_ADDR_BUF_CFG:     addr_to_idx = 3'h0;
            BIMF_ADDR_WM_COUNT:    addr_to_idx = 3'h1;
            BIMF_ADDR_PIN_A_ROUTE: addr_to_idx = 3'h2;
            BIMF_ADDR_PIN_B_ROUTE: addr_to_idx = 3'h3;
            BIMF_ADDR_SAMPLE_CFG:  addr_to_idx = 3'h4;
            default:               addr_to_idx = 3'h7;
        endcase
    endfunction

    typedef struct packed {
        logic [1:0]            pin_o;
        logic [1:0]            pin_oe_n;
        logic [NUM_EVENTS-1:0] status;
        logic                  rvalid;
        logic [1:0]            trig_sync;
        logic                  trig_prev;
        logic                  trig_pulse;
    } bimf_state_t;

    bimf_state_t st_r, st_nxt;

    logic [2:0]                    wr_idx;
    logic [2:0]                    rd_idx;
    logic [7:0]                    wr_val;
    logic [7:0]                    rd_data;
    logic [BIMF_NUM_REGS*8-1:0]    regs_flat;
    logic [7:0]                    buf_cfg;
    logic [7:0]                    wm_count;
    logic [1:0][7:0]               route;
    logic [7:0]                    smp_cfg;
    logic [1:0]                    pin_active;
    logic [1:0]                    pin_any_routed;
    logic                          trig_level;

    assign wr_idx = addr_to_idx(reg_addr);
    assign rd_idx = addr_to_idx(reg_addr);
    // Unused top nibble of buffer config reads back as zero
    assign wr_val = (wr_idx == 3'h0) ? (reg_wdata & BIMF_BUF_CFG_WMASK) : reg_wdata;

    bimf_reg_store #(
        .DEPTH (BIMF_NUM_REGS)
    ) u_store (
        .ref_clk (ref_clk),
        .srst    (srst),
        .wr_en   (reg_wr),
        .wr_idx  (wr_idx),
        .wr_data (wr_val),
        .rd_idx  (rd_idx),
        .rd_data (rd_data),
        .all_q   (regs_flat)
    );

    assign buf_cfg  = regs_flat[7:0];
    assign wm_count = regs_flat[15:8];
    assign route[0] = regs_flat[23:16];
    assign route[1] = regs_flat[31:24];
    assign smp_cfg  = regs_flat[39:32];

    assign buffer_mode   = buf_cfg[BIMF_BUF_MODE_LSB +: 2];
    assign buffer_enable = (bimf_buf_mode_t'(buffer_mode) != BIMF_BUF_OFF);
    assign buffer_temp_store = buf_cfg[BIMF_BUF_TEMP_BIT];
    assign buffer_watermark_level = {buf_cfg[BIMF_COUNT_TOP_BIT], wm_count};

    assign range_select = smp_cfg[BIMF_RANGE_LSB + 1] ? BIMF_RANGE_8G
                        : (smp_cfg[BIMF_RANGE_LSB] ? BIMF_RANGE_4G : BIMF_RANGE_2G);
    // bandwidth divider: 4 when narrow, else 2
    assign narrow_filter_select = smp_cfg[BIMF_NARROW_BIT];
    assign filter_bw_div_log2   = narrow_filter_select ? 3'h2 : 3'h1;
    // codes 101..111 all mean 400 Hz
    assign sample_rate_index = (smp_cfg[BIMF_RATE_LSB +: 3] > BIMF_RATE_MAX_IDX)
                             ? BIMF_RATE_MAX_IDX : smp_cfg[BIMF_RATE_LSB +: 3];
    assign external_trigger_select = smp_cfg[BIMF_EXT_TRIG_BIT];

    generate
        for (genvar p = 0; p < 2; p++) begin : g_pin
            assign pin_any_routed[p] = |route[p][NUM_EVENTS-1:0];
            assign pin_active[p]     = |(route[p][NUM_EVENTS-1:0] & event_state);
        end
    endgenerate

    assign trig_level = st_r.trig_sync[1];

    always_comb begin
        st_nxt = st_r;
        st_nxt.rvalid     = reg_rd;
        st_nxt.status     = event_state;
        // Two stages before any logic reads the pin
        st_nxt.trig_sync  = {st_r.trig_sync[0], irq_pin_b_i};
        st_nxt.trig_prev  = trig_level;
        st_nxt.trig_pulse = external_trigger_select && trig_level && !st_r.trig_prev;
        for (int p = 0; p < 2; p++) begin
            st_nxt.pin_o[p]    = pin_active[p] ^ route[p][BIMF_POL_INV_BIT];
            st_nxt.pin_oe_n[p] = !pin_any_routed[p];
        end
        // pin B released from the edge after it becomes an input
        if (external_trigger_select) begin
            st_nxt.pin_oe_n[1] = 1'b1;
        end
        // Released pins keep last level, modelling the keeper
        for (int p = 0; p < 2; p++) begin
            if (st_nxt.pin_oe_n[p]) begin
                st_nxt.pin_o[p] = st_r.pin_o[p];
            end
        end
        if (srst) begin
            st_nxt = '0;
            st_nxt.pin_oe_n = 2'b11;
        end
    end

    always_ff @(posedge ref_clk) begin
        st_r <= st_nxt;
    end

    // Store read data lands one edge after the request
    assign reg_rdata  = st_r.rvalid ? rd_data : 8'h00;
    assign reg_rvalid = st_r.rvalid;
    assign event_status           = st_r.status;
    assign irq_pin_a_o            = st_r.pin_o[0];
    assign irq_pin_a_oe_n         = st_r.pin_oe_n[0];
    assign irq_pin_b_o            = st_r.pin_o[1];
    assign irq_pin_b_oe_n         = st_r.pin_oe_n[1];
    assign external_trigger_pulse = st_r.trig_pulse;
endmodule

/* design/bimf_pkg.sv */
// Package: register map, field layout and decoded modes of the configuration bank
package bimf_pkg;
    localparam logic [7:0] BIMF_ADDR_BUF_CFG     = 8'h28;
    localparam logic [7:0] BIMF_ADDR_WM_COUNT    = 8'h29;
    localparam logic [7:0] BIMF_ADDR_PIN_A_ROUTE = 8'h2A;
    localparam logic [7:0] BIMF_ADDR_PIN_B_ROUTE = 8'h2B;
    localparam logic [7:0] BIMF_ADDR_SAMPLE_CFG  = 8'h2C;
    localparam int         BIMF_NUM_REGS         = 5;
    localparam logic [7:0] BIMF_RST_BUF_CFG      = 8'h00;
    localparam logic [7:0] BIMF_RST_WM_COUNT     = 8'h80;
    localparam logic [7:0] BIMF_RST_ROUTE        = 8'h00;
    localparam logic [7:0] BIMF_RST_SAMPLE_CFG   = 8'h13;
    localparam logic [7:0] BIMF_BUF_CFG_WMASK    = 8'h0F;
    localparam int BIMF_BUF_MODE_LSB   = 0;
    localparam int BIMF_BUF_TEMP_BIT   = 2;
    localparam int BIMF_COUNT_TOP_BIT  = 3;
    localparam int BIMF_POL_INV_BIT    = 7;
    localparam int BIMF_NUM_EVENTS     = 7;
    localparam int BIMF_RANGE_LSB      = 6;
    localparam int BIMF_NARROW_BIT     = 4;
    localparam int BIMF_EXT_TRIG_BIT   = 3;
    localparam int BIMF_RATE_LSB       = 0;
    localparam int BIMF_COUNT_W        = 9;
    typedef enum logic [1:0] {
        BIMF_BUF_OFF, BIMF_BUF_OLDEST, BIMF_BUF_STREAM, BIMF_BUF_TRIGGERED
    } bimf_buf_mode_t;
    typedef enum logic [1:0] {
        BIMF_RANGE_2G, BIMF_RANGE_4G, BIMF_RANGE_8G
    } bimf_range_t;
    // Rate index: 0=12.5 Hz ... 5=400 Hz
    localparam logic [2:0] BIMF_RATE_MAX_IDX = 3'h5;
endpackage

/* design/bimf_reg_store.sv */
// Small register store with registered read data
`timescale 1ns/10ps
module bimf_reg_store
    import bimf_pkg::*;
#(
    parameter int DEPTH = BIMF_NUM_REGS
) (
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire logic             wr_en,
    input  wire logic [2:0]       wr_idx,
    input  wire logic [7:0]       wr_data,
    input  wire logic [2:0]       rd_idx,
    output logic      [7:0]       rd_data,
    output logic [DEPTH*8-1:0]    all_q
);
    initial begin
        if (DEPTH != BIMF_NUM_REGS) $error("bimf_reg_store: DEPTH must be 5");
    end

    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
        logic [7:0]            rd;
    } bimf_store_t;

    bimf_store_t s_r, s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (wr_en && 32'(wr_idx) < DEPTH) begin
            s_nxt.mem[wr_idx] = wr_data;
        end
        s_nxt.rd = (32'(rd_idx) < DEPTH) ? s_r.mem[rd_idx] : 8'h00;
        if (srst) begin
            s_nxt.mem[0] = BIMF_RST_BUF_CFG;
            s_nxt.mem[1] = BIMF_RST_WM_COUNT;
            s_nxt.mem[2] = BIMF_RST_ROUTE;
            s_nxt.mem[3] = BIMF_RST_ROUTE;
            s_nxt.mem[4] = BIMF_RST_SAMPLE_CFG;
            s_nxt.rd     = 8'h00;
        end
    end

    always_ff @(posedge ref_clk) begin
        s_r <= s_nxt;
    end

    assign rd_data = s_r.rd;
    assign all_q   = s_r.mem;
endmodule

/* dv/bimf_asserts.sv */
// Checker for the configuration bank ports
`timescale 1ns/10ps
module bimf_asserts #(
    parameter int NUM_EVENTS = 7
) (
    input wire logic                  ref_clk,
    input wire logic                  srst,
    input wire logic                  reg_wr,
    input wire logic [7:0]            reg_addr,
    input wire logic [7:0]            reg_wdata,
    input wire logic [NUM_EVENTS-1:0] event_state,
    input wire logic [NUM_EVENTS-1:0] event_status,
    input wire logic                  irq_pin_a_o,
    input wire logic                  irq_pin_a_oe_n,
    input wire logic                  irq_pin_b_oe_n,
    input wire logic [1:0]            buffer_mode,
    input wire logic                  buffer_enable,
    input wire logic                  buffer_temp_store,
    input wire logic [8:0]            buffer_watermark_level,
    input wire logic [1:0]            range_select,
    input wire logic                  narrow_filter_select,
    input wire logic [2:0]            sample_rate_index,
    input wire logic [2:0]            filter_bw_div_log2,
    input wire logic                  external_trigger_select,
    input wire logic                  external_trigger_pulse
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    wire w28 = reg_wr && reg_addr == 8'h28;
    wire w2c = reg_wr && reg_addr == 8'h2C;
    // Shadow of pin A routing, only to time the pin
    logic [7:0] ra_r;
    always_ff @(posedge ref_clk) ra_r <= srst ? 8'h00 : ((reg_wr && reg_addr == 8'h2A) ? reg_wdata : ra_r);
    buf_mode_a: assert property (w28 |=> buffer_mode == $past(reg_wdata[1:0]) &&
        buffer_enable == ($past(reg_wdata[1:0]) != 2'h0)) else $error("buffer mode wrong");
    count_top_a: assert property (w28 |=> buffer_watermark_level[8] == $past(reg_wdata[3]))
        else $error("count top bit wrong");
    temp_store_a: assert property (w28 |=> buffer_temp_store == $past(reg_wdata[2]))
        else $error("temp store wrong");
    count_low_a: assert property (reg_wr && reg_addr == 8'h29 |=>
        buffer_watermark_level[7:0] == $past(reg_wdata)) else $error("count low bits wrong");
    count_reset_a: assert property ($past(srst) |-> buffer_watermark_level == 9'h080)
        else $error("count reset value wrong");
    range_sel_a: assert property (w2c |=> range_select ==
        ($past(reg_wdata[7]) ? 2'h2 : {1'b0, $past(reg_wdata[6])})) else $error("range wrong");
    rate_sat_a: assert property (w2c |=> sample_rate_index ==
        (($past(reg_wdata[2:0]) > 3'h5) ? 3'h5 : $past(reg_wdata[2:0]))) else $error("rate wrong");
    bw_div_a: assert property (filter_bw_div_log2 == (narrow_filter_select ? 3'h2 : 3'h1))
        else $error("bandwidth divider wrong");
    trig_release_a: assert property (external_trigger_select && $past(external_trigger_select)
        |-> irq_pin_b_oe_n) else $error("pin B driven in trigger mode");
    status_copy_a: assert property (!$past(srst) |-> event_status == $past(event_state))
        else $error("status copy wrong");
    pin_a_drive_a: assert property (!$past(srst) |-> irq_pin_a_oe_n == ($past(ra_r[6:0]) == 7'h00))
        else $error("pin A enable wrong");
    pin_a_level_a: assert property (!$past(srst) && !irq_pin_a_oe_n |-> irq_pin_a_o ==
        ($past(|(event_state & ra_r[6:0])) ^ $past(ra_r[7]))) else $error("pin A level wrong");
    cover property (!irq_pin_a_oe_n && irq_pin_a_o);
    cover property (w2c && reg_wdata[3]);
    cover property (external_trigger_pulse);
endmodule

bind bimf_config_bank bimf_asserts #(.NUM_EVENTS(NUM_EVENTS)) u_chk (.*);

/* dv/bimf_host_model.sv */
// Host model issuing register writes and reads
`timescale 1ns/10ps
module bimf_host_model (
    input  wire logic       ref_clk,
    output logic            reg_wr = 1'b0,
    output logic            reg_rd = 1'b0,
    output logic [7:0]      reg_addr = 8'h00,
    output logic [7:0]      reg_wdata = 8'h00,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    // Idle cycle first so a strobe never changes twice in one step
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge ref_clk) #1;
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(posedge ref_clk) #1;
        // Released bus shows the inverse, not a stale value
        {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
    endtask
    task automatic rd(logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge ref_clk) #1;
        {reg_rd, reg_addr} = {1'b1, a};
        @(posedge ref_clk) #1;
        {reg_rd, reg_addr} = {1'b0, ~a};
        for (int k = 0; k < 3 && reg_rvalid !== 1'b1; k++) @(posedge ref_clk) #1;
        d = reg_rdata;
        ok = reg_rvalid;
    endtask
endmodule

/* dv/testbench.sv */
// Self-checking bench for the configuration bank
`timescale 1ns/10ps
module testbench;
    logic       ref_clk = 1'b0, srst = 1'b1, pb_drv = 1'b0;
    logic [6:0] event_state = 7'h00, event_status;
    logic       reg_wr, reg_rd, reg_rvalid, irq_pin_a_o, irq_pin_a_oe_n, irq_pin_b_o, irq_pin_b_oe_n;
    logic       buffer_enable, buffer_temp_store, narrow_filter_select, external_trigger_select;
    logic       external_trigger_pulse;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [1:0] buffer_mode, range_select;
    logic [8:0] buffer_watermark_level;
    logic [2:0] sample_rate_index, filter_bw_div_log2;
    wire        irq_pin_b_i = irq_pin_b_oe_n ? pb_drv : irq_pin_b_o;
    int         m[5] = '{0, 'h80, 0, 0, 'h13};
    int         lv[2] = '{0, 0};
    int         fail_count = 0, samples_checked = 0, r, k;
    bimf_config_bank uut (.*);
    bimf_host_model host (.*);
    always #10 ref_clk = ~ref_clk;
    task automatic chk(string n, logic [8:0] e, logic [8:0] s);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Upper nibble of buffer_config is not kept
    task automatic wr(int a, int d);
        host.wr(a[7:0], d[7:0]);
        if (a >= 40 && a <= 44) m[a-40] = (a == 40) ? (d & 15) : (d & 255);
    endtask
    task automatic rdc(int a);
        logic [7:0] d;
        logic ok;
        host.rd(a[7:0], d, ok);
        chk("rvalid", 1, ok);
        if (ok !== 1'b1) close_out();
        chk("rdata", (a >= 40 && a <= 44) ? m[a-40] : 0, d);
    endtask
    task automatic cfgc();
        chk("mode", m[0] & 3, buffer_mode);
        chk("enable", (m[0] & 3) != 0, buffer_enable);
        chk("temp", m[0] >> 2 & 1, buffer_temp_store);
        chk("level", (m[0] >> 3 & 1) * 256 + m[1], buffer_watermark_level);
        chk("range", (m[4] >> 7) ? 2 : (m[4] >> 6 & 1), range_select);
        chk("narrow", m[4] >> 4 & 1, narrow_filter_select);
        chk("bw", (m[4] >> 4 & 1) ? 2 : 1, filter_bw_div_log2);
        chk("rate", ((m[4] & 7) > 5) ? 5 : (m[4] & 7), sample_rate_index);
        chk("ext", m[4] >> 3 & 1, external_trigger_select);
    endtask
    // Released pin keeps the last driven level
    task automatic pinc();
        for (int p = 0; p < 2; p++) begin
            r = m[2+p];
            if (r & 127) lv[p] = ((event_state & r & 127) != 0) ^ (r >> 7 & 1);
            chk("oe", (r & 127) == 0, p ? irq_pin_b_oe_n : irq_pin_a_oe_n);
            chk("pin", lv[p], p ? irq_pin_b_o : irq_pin_a_o);
        end
        chk("status", event_state, event_status);
    endtask
    initial begin
        r = $urandom(32'h823BDE25);
        repeat (16) @(posedge ref_clk);
        #1 srst = 1'b0;
        for (int a = 39; a <= 45; a++) rdc(a);
        cfgc();
        $display("reset values done");
        for (int i = 0; i < 16; i++) begin
            wr(40, (i & 3) | ($urandom & 'hFC));
            wr(41, $urandom);
            wr(44, (i < 8) ? (((i & 3) << 6) | ((i & 1) << 4) | i) : ($urandom & 'hF7));
            cfgc();
            for (int a = 40; a <= 44; a += 2) rdc(a);
        end
        $display("config fields done");
        for (int i = 0; i < 24; i++) begin
            wr(42, (i % 4 == 0) ? ($urandom & 'h80) : $urandom);
            wr(43, (i % 5 == 0) ? ($urandom & 'h80) : $urandom);
            event_state = $urandom;
            @(posedge ref_clk) #1;
            pinc();
        end
        $display("pin routing done");
        wr(44, 'h1B);
        repeat (4) @(posedge ref_clk) #1;
        chk("oe_b", 1, irq_pin_b_oe_n);
        cfgc();
        pb_drv = 1'b1;
        for (k = 0; k < 8 && external_trigger_pulse !== 1'b1; k++) @(posedge ref_clk) #1;
        chk("trigger", 1, external_trigger_pulse);
        if (k == 8) close_out();
        $display("external trigger done");
        close_out();
    end
endmodule
